// ===== rtl/cmu_core_timing.sv
// CPU execution timing, register file and MAC control behind an APB slave
// ---------------------------------------------------------------------------
// Top level
// ---------------------------------------------------------------------------
// Summary of operation
// - Fuse cleared selects fast mode, fetching one internal code byte every clock.
// - Fast mode takes one clock per byte; branches and calls add one.
// - Fast mode from external program memory takes three times as long.
// - Compatibility mode is default and chosen whenever the fuse is set.
// - Compatibility fetches every third clock; six states on halved clock.
// - Compatibility instructions take one, two or four twelve-clock machine cycles.
// - Compatibility timing is the same for internal and external memory.
// - MAC adds the signed 32-bit product into the 40-bit M register.
// - Operands are operand_a_high_byte:ACC and operand_b_high_byte:B.
// - MAC takes nine cycles in fast mode from internal memory, sequential partial products, operands untouched.
// - MAC sets carry to sign, overflow sticky once set.
// - Clear instruction zeroes all of M in two cycles.
// - Shift instructions move M left one bit or right arithmetically.
// - Window field picks byte pairs 1:0, 2:1, 3:2 or 4:3 of M.
// - Sign select bits steer only the 8x8 multiply, never the MAC.
// - Configuration register resets to zero; window 7:6, signs 5 and 4.
module cmu_core_timing
  import cmu_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Configuration fuse pin
  input  wire logic              compat_fuse,
  // Code memory fetch and instruction progress
  output logic                   fetch_req,
  output logic                   instr_busy,
  output logic                   instr_done
);

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_RUN} cmu_state_e;

  cmu_state_e  state_ff;
  cmu_cmd_s    cmd_ff;
  logic        fuse_meta_ff;
  logic        fuse_sync_ff;
  logic        compat_ff;
  logic [7:0]  opa_hi_ff;
  logic [7:0]  opb_hi_ff;
  logic [7:0]  cfg_ff;
  logic [7:0]  acc_ff;
  logic [7:0]  b_ff;
  logic        carry_ff;
  logic        ovf_ff;
  logic [7:0]  cyc_left_ff;
  logic [7:0]  cyc_total_ff;
  logic [1:0]  fetch_div_ff;
  logic [1:0]  fetched_ff;
  logic        half_ff;
  logic [2:0]  mstate_ff;
  logic        done_ff;
  logic        fetch_ff;
  logic [31:0] prdata_ff;
  logic [7:0]  idx;
  logic        addr_ok;
  logic        mapped;
  logic        wr_en;
  logic        setup;
  logic        issue;
  cmu_cmd_s    nxt_cmd;
  logic [7:0]  nxt_total;
  logic [7:0]  base_fast;
  logic [7:0]  mc_count;
  logic [1:0]  fetch_bytes;
  logic        fetch_due;
  logic        slow_fetch;
  cmu_mop_e    mop;
  logic [39:0] m_val;
  cmu_flag_s   mac_flags;
  logic [15:0] mul_res;
  logic [7:0]  win_lo;
  logic [7:0]  win_hi;
  logic [1:0]  win_sel;

  // -------------------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------------------
  // Only word aligned addresses inside the index range are decoded
  assign idx     = paddr[9:2];
  assign addr_ok = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
  assign mapped  = addr_ok && (idx == IDX_OPA_HI || idx == IDX_OPB_HI ||
                               idx == IDX_DSP_CFG || idx == IDX_WIN_LO ||
                               idx == IDX_WIN_HI || idx == IDX_ACC ||
                               idx == IDX_B || idx == IDX_FLAGS ||
                               idx == IDX_CMD || idx == IDX_STATUS);
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_ff;

  // -------------------------------------------------------------------------
  // Fuse synchroniser and mode
  // -------------------------------------------------------------------------
  // The fuse is a pin, so two flops come before any logic reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_meta_ff <= 1'b1;
      fuse_sync_ff <= 1'b1;
    end else begin
      fuse_meta_ff <= compat_fuse;
      fuse_sync_ff <= fuse_meta_ff;
    end
  end

  // Mode is caught at issue so a fuse change never splits an instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compat_ff <= 1'b1;
    end else if (issue) begin
      compat_ff <= fuse_sync_ff;
    end
  end

  // -------------------------------------------------------------------------
  // Instruction issue and cycle count
  // -------------------------------------------------------------------------
  // A command write while an instruction runs is dropped
  assign nxt_cmd = cmu_cmd_s'(pwdata[$bits(cmu_cmd_s)-1:0]);
  assign issue   = wr_en && idx == IDX_CMD && state_ff == ST_IDLE;

  // Execution length of the command being issued
  always_comb begin
    if (nxt_cmd.is_ext) begin
      unique case (nxt_cmd.opcode)
        OPC_MULTIPLY_ACCUMULATE_INSTR: base_fast = MAC_CYCLES;
        OPC_CLEAR_ACCUM_INSTR:  base_fast = CLRM_CYCLES;
        default:    base_fast = SHIFT_CYCLES;
      endcase
    end else begin
      base_fast = {6'h0, (nxt_cmd.nbytes == 2'h0) ? 2'h1 : nxt_cmd.nbytes} +
                  (nxt_cmd.branch ? BRANCH_EXTRA : 8'h0);
    end
    unique case (nxt_cmd.mc_code)
      2'h0:    mc_count = 8'h01;
      2'h1:    mc_count = 8'h02;
      default: mc_count = 8'h04;
    endcase
    if (fuse_sync_ff) begin
      nxt_total = 8'(mc_count * CLKS_PER_MC);
    end else if (nxt_cmd.ext_mem) begin
      nxt_total = 8'(base_fast * EXT_MEM_FACTOR);
    end else begin
      nxt_total = base_fast;
    end
  end

  // Run state: count down the cycles and pulse done on the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= ST_IDLE;
      cmd_ff       <= '0;
      cyc_left_ff  <= 8'h0;
      cyc_total_ff <= 8'h0;
      done_ff      <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          if (issue) begin
            state_ff     <= ST_RUN;
            cmd_ff       <= nxt_cmd;
            cyc_left_ff  <= nxt_total - 8'h1;
            cyc_total_ff <= nxt_total;
          end
        end
        ST_RUN: begin
          if (cyc_left_ff == 8'h0) begin
            state_ff <= ST_IDLE;
            done_ff  <= 1'b1;
          end else begin
            cyc_left_ff <= cyc_left_ff - 8'h1;
          end
        end
      endcase
    end
  end

  assign instr_busy = (state_ff == ST_RUN);
  assign instr_done = done_ff;

  // -------------------------------------------------------------------------
  // Code fetch pacing
  // -------------------------------------------------------------------------
  // External fast fetches and compatibility fetches come every third clock
  assign slow_fetch  = compat_ff || cmd_ff.ext_mem;
  assign fetch_bytes = cmd_ff.is_ext ? EXT_BYTES[1:0] :
                       (cmd_ff.nbytes == 2'h0) ? 2'h1 : cmd_ff.nbytes;
  assign fetch_due   = instr_busy && fetched_ff < fetch_bytes && fetch_div_ff == 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_div_ff <= 2'h0;
      fetched_ff   <= 2'h0;
      fetch_ff     <= 1'b0;
    end else if (issue) begin
      fetch_div_ff <= 2'h0;
      fetched_ff   <= 2'h0;
      fetch_ff     <= 1'b0;
    end else begin
      fetch_ff <= fetch_due;
      if (fetch_due) fetched_ff <= fetched_ff + 2'h1;
      if (!slow_fetch || fetch_div_ff == COMPAT_FETCH_DIV) begin
        fetch_div_ff <= 2'h0;
      end else begin
        fetch_div_ff <= fetch_div_ff + 2'h1;
      end
    end
  end

  assign fetch_req = fetch_ff;

  // -------------------------------------------------------------------------
  // Compatibility machine cycle states
  // -------------------------------------------------------------------------
  // Halved clock enable drives six states, twelve clocks per machine cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff   <= 1'b0;
      mstate_ff <= 3'h0;
    end else if (issue || !instr_busy || !compat_ff) begin
      half_ff   <= 1'b0;
      mstate_ff <= 3'h0;
    end else begin
      half_ff <= !half_ff;
      if (half_ff) begin
        mstate_ff <= (mstate_ff == STATES_PER_MC - 3'h1) ? 3'h0 : mstate_ff + 3'h1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // MAC datapath
  // -------------------------------------------------------------------------
  // Extended opcodes start the datapath on the issue edge
  always_comb begin
    mop = MOP_NONE;
    if (issue && nxt_cmd.is_ext) begin
      unique case (nxt_cmd.opcode)
        OPC_MULTIPLY_ACCUMULATE_INSTR: mop = MOP_MAC;
        OPC_CLEAR_ACCUM_INSTR:  mop = MOP_CLR;
        OPC_SHIFT_LEFT_ACCUM_INSTR:  mop = MOP_SHL;
        OPC_ASR_M:  mop = MOP_SHR;
        default:    mop = MOP_NONE;
      endcase
    end
  end

  assign win_sel = cfg_ff[CFG_WIN_LSB +: 2];

  // Operands are only read, never written back
  cmu_mac_unit u_mac (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (mop != MOP_NONE),
    .op      (mop),
    .opa     ({opa_hi_ff, acc_ff}),
    .opb     ({opb_hi_ff, b_ff}),
    .win_sel (win_sel),
    .wr_lo   (wr_en && idx == IDX_WIN_LO),
    .wr_hi   (wr_en && idx == IDX_WIN_HI),
    .wr_data (pwdata[7:0]),
    .m_out   (m_val),
    .flags   (mac_flags)
  );

  // Sliding window onto M
  assign win_lo = m_val[8*win_sel +: 8];
  assign win_hi = m_val[8*win_sel + 8 +: 8];

  // -------------------------------------------------------------------------
  // 8x8 multiply with selectable operand signs
  // -------------------------------------------------------------------------
  assign mul_res = 16'($signed({cfg_ff[CFG_SIGNED_OPERAND_A_SEL_BIT] & acc_ff[7], acc_ff}) *
                       $signed({cfg_ff[CFG_SIGNED_OPERAND_B_SEL_BIT] & b_ff[7], b_ff}));

  // -------------------------------------------------------------------------
  // Software registers
  // -------------------------------------------------------------------------
  // Configuration and high operand bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff    <= CFG_RESET;
      opa_hi_ff <= 8'h00;
      opb_hi_ff <= 8'h00;
    end else if (wr_en) begin
      if (idx == IDX_DSP_CFG) cfg_ff <= pwdata[7:0];
      if (idx == IDX_OPA_HI)  opa_hi_ff <= pwdata[7:0];
      if (idx == IDX_OPB_HI)  opb_hi_ff <= pwdata[7:0];
    end
  end

  // ACC and B: the multiply result wins over a software write that lands with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= 8'h00;
      b_ff   <= 8'h00;
    end else if (done_ff && !cmd_ff.is_ext && cmd_ff.opcode == OPC_MUL_AB) begin
      acc_ff <= mul_res[7:0];
      b_ff   <= mul_res[15:8];
    end else if (wr_en) begin
      if (idx == IDX_ACC) acc_ff <= pwdata[7:0];
      if (idx == IDX_B)   b_ff <= pwdata[7:0];
    end
  end

  // Flags: hardware results win, and a set overflow is never lost to a MAC
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_ff <= 1'b0;
      ovf_ff   <= 1'b0;
    end else if (mac_flags.valid) begin
      carry_ff <= mac_flags.carry;
      ovf_ff   <= ovf_ff | mac_flags.ovf;
    end else if (done_ff && !cmd_ff.is_ext && cmd_ff.opcode == OPC_MUL_AB) begin
      carry_ff <= 1'b0;
      ovf_ff   <= (mul_res[15:8] != 8'h00);
    end else if (wr_en && idx == IDX_FLAGS) begin
      carry_ff <= pwdata[FLG_C_BIT];
      ovf_ff   <= pwdata[FLG_OV_BIT];
    end
  end

  // -------------------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------------------
  // Captured in the setup phase so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (setup) begin
      prdata_ff <= 32'h0;
      if (addr_ok) begin
        unique case (idx)
          IDX_OPA_HI:  prdata_ff[7:0] <= opa_hi_ff;
          IDX_OPB_HI:  prdata_ff[7:0] <= opb_hi_ff;
          IDX_DSP_CFG: prdata_ff[7:0] <= cfg_ff;
          IDX_WIN_LO:  prdata_ff[7:0] <= win_lo;
          IDX_WIN_HI:  prdata_ff[7:0] <= win_hi;
          IDX_ACC:     prdata_ff[7:0] <= acc_ff;
          IDX_B:       prdata_ff[7:0] <= b_ff;
          IDX_FLAGS: begin
            prdata_ff[FLG_C_BIT]  <= carry_ff;
            prdata_ff[FLG_OV_BIT] <= ovf_ff;
          end
          IDX_CMD:     prdata_ff[$bits(cmu_cmd_s)-1:0] <= cmd_ff;
          IDX_STATUS:  prdata_ff[23:0] <= {cyc_total_ff, cyc_left_ff,
                                           2'b00, mstate_ff, fuse_sync_ff,
                                           compat_ff, instr_busy};
          default:     prdata_ff <= 32'h0;
        endcase
      end
    end
  end

endmodule

// ===== rtl/cmu_pkg.sv
// Shared constants, types and register map for the CPU timing and MAC unit
package cmu_pkg;

  // ---------------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_OPA_HI   = 8'hE1;
  localparam logic [7:0] IDX_OPB_HI   = 8'hF7;
  localparam logic [7:0] IDX_DSP_CFG  = 8'hE2;
  localparam logic [7:0] IDX_WIN_LO   = 8'hE4;
  localparam logic [7:0] IDX_WIN_HI   = 8'hE5;
  localparam logic [7:0] IDX_ACC      = 8'hE0;
  localparam logic [7:0] IDX_B        = 8'hF0;
  localparam logic [7:0] IDX_FLAGS    = 8'hD0;
  localparam logic [7:0] IDX_CMD      = 8'hC0;
  localparam logic [7:0] IDX_STATUS   = 8'hC1;
  localparam int         ADDR_W       = 12;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int         CFG_WIN_LSB  = 6;
  localparam int         CFG_SIGNED_OPERAND_B_SEL_BIT = 5;
  localparam int         CFG_SIGNED_OPERAND_A_SEL_BIT = 4;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam int         FLG_C_BIT    = 7;
  localparam int         FLG_OV_BIT   = 2;
  localparam logic [7:0] OPC_MUL_AB   = 8'hA4;
  localparam logic [7:0] OPC_MULTIPLY_ACCUMULATE_INSTR   = 8'hA4;
  localparam logic [7:0] OPC_CLEAR_ACCUM_INSTR    = 8'hE4;
  localparam logic [7:0] OPC_SHIFT_LEFT_ACCUM_INSTR    = 8'h23;
  localparam logic [7:0] OPC_ASR_M    = 8'h03;

  // ---------------------------------------------------------------------
  // Timing counts in system clock cycles
  // ---------------------------------------------------------------------
  localparam logic [7:0] MAC_CYCLES       = 8'h09;
  localparam logic [7:0] CLRM_CYCLES      = 8'h02;
  localparam logic [7:0] SHIFT_CYCLES     = 8'h02;
  localparam logic [7:0] EXT_BYTES        = 8'h02;
  localparam logic [7:0] BRANCH_EXTRA     = 8'h01;
  localparam logic [7:0] EXT_MEM_FACTOR   = 8'h03;
  localparam logic [7:0] CLKS_PER_MC      = 8'h0C;
  localparam logic [1:0] COMPAT_FETCH_DIV = 2'h2;
  localparam logic [2:0] STATES_PER_MC    = 3'h6;

  // Operations handed to the MAC datapath
  typedef enum logic [2:0] {MOP_NONE, MOP_MAC, MOP_CLR, MOP_SHL, MOP_SHR} cmu_mop_e;

  // Instruction issue word written to the command register
  typedef struct packed {
    logic [1:0] mc_code;
    logic       is_ext;
    logic       ext_mem;
    logic       branch;
    logic [1:0] nbytes;
    logic [7:0] opcode;
  } cmu_cmd_s;

  // Flag result from the MAC datapath
  typedef struct packed {
    logic valid;
    logic carry;
    logic ovf;
  } cmu_flag_s;

endpackage

// ===== rtl/cmu_mac_unit.sv
// Sequential 16x16 multiply-accumulate datapath with 40-bit M register
module cmu_mac_unit
  import cmu_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Operation request
  input  wire logic        start,
  input  wire cmu_mop_e    op,
  input  wire logic [15:0] opa,
  input  wire logic [15:0] opb,
  // Window writes
  input  wire logic [1:0]  win_sel,
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wr_data,
  // Results
  output logic [39:0]      m_out,
  output cmu_flag_s        flags
);

  logic [39:0] m_ff;
  logic [32:0] prod_ff;
  logic [2:0]  step_ff;
  logic        run_ff;
  logic [17:0] pp;
  logic [32:0] pp_shift;
  logic [40:0] sum;

  // Partial product of one byte pair; high bytes carry the sign
  always_comb begin
    pp = 18'($signed({step_ff[1] & opa[15], step_ff[1] ? opa[15:8] : opa[7:0]}) *
              $signed({step_ff[0] & opb[15], step_ff[0] ? opb[15:8] : opb[7:0]}));
    pp_shift = 33'($signed(pp)) <<< ((5'(step_ff[1]) + 5'(step_ff[0])) * 5'd8);
    sum = 41'($signed(m_ff)) + 41'($signed(prod_ff));
  end

  // Four partial products then one 40-bit add, well inside nine cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff  <= 1'b0;
      step_ff <= 3'h0;
      prod_ff <= 33'h0;
    end else if (start && op == MOP_MAC) begin
      run_ff  <= 1'b1;
      step_ff <= 3'h0;
      prod_ff <= 33'h0;
    end else if (run_ff) begin
      if (step_ff[2]) begin
        run_ff <= 1'b0;
      end else begin
        prod_ff <= prod_ff + pp_shift;
        step_ff <= step_ff + 3'h1;
      end
    end
  end

  // M register: accumulate, clear, shift, or byte writes through the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ff <= 40'h0;
    end else if (run_ff && step_ff[2]) begin
      m_ff <= sum[39:0];
    end else if (start && op == MOP_CLR) begin
      m_ff <= 40'h0;
    end else if (start && op == MOP_SHL) begin
      m_ff <= {m_ff[38:0], 1'b0};
    end else if (start && op == MOP_SHR) begin
      m_ff <= {m_ff[39], m_ff[39:1]};
    end else if (!run_ff) begin
      if (wr_lo) m_ff[8*win_sel +: 8] <= wr_data;
      if (wr_hi) m_ff[8*win_sel + 8 +: 8] <= wr_data;
    end
  end

  // Carry is the result sign, overflow when signs of addends agree and sum differs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags.valid <= run_ff && step_ff[2];
      flags.carry <= sum[39];
      flags.ovf   <= (m_ff[39] == prod_ff[32]) && (sum[39] != m_ff[39]);
    end
  end

  assign m_out = m_ff;

endmodule

// ===== test/cmu_core_timing_assertions.sv
// Port-level timing checks for the CPU timing and MAC unit
module cmu_core_timing_assertions
  import cmu_pkg::*;
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB slave side
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Fuse and instruction progress
  input wire logic              compat_fuse,
  input wire logic              fetch_req,
  input wire logic              instr_busy,
  input wire logic              instr_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Command decode and settled fuse level
  // ------------------------------------------------------------
  logic [2:0] fuse_hist_ff;
  logic       cmd_wr;
  logic       fast;
  logic       cmpt;
  // History resets to compat so a fresh fuse level is trusted only once settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fuse_hist_ff <= 3'h7;
    else fuse_hist_ff <= {fuse_hist_ff[1:0], compat_fuse};
  end
  assign cmd_wr = psel && penable && pwrite && !instr_busy &&
                  paddr == {2'b00, IDX_CMD, 2'b00};
  assign fast = ~|{fuse_hist_ff, compat_fuse};
  assign cmpt = &{fuse_hist_ff, compat_fuse};
  property p_fast_fetch;
    cmd_wr && fast && pwdata[12:8] == 5'h02 |-> ##2 fetch_req ##1 fetch_req;
  endproperty
  a_fast_fetch: assert property (p_fast_fetch) else $error("fetch not every clock");
  property p_ext_triple;
    cmd_wr && fast && pwdata[12:8] == 5'h09 |=> instr_busy [*3] ##1 (!instr_busy && instr_done);
  endproperty
  a_ext_triple: assert property (p_ext_triple) else $error("external fetch not 3x");
  property p_compat_mc;
    cmd_wr && cmpt && pwdata[14:13] == 2'h0
      |=> instr_busy [*8] ##1 instr_busy [*4] ##1 (!instr_busy && instr_done);
  endproperty
  a_compat_mc: assert property (p_compat_mc) else $error("machine cycle not 12");
  property p_compat_fetch;
    fetch_req && cmpt |=> !fetch_req [*2];
  endproperty
  a_compat_fetch: assert property (p_compat_fetch) else $error("fetch gap under 3");
  property p_mac_nine;
    cmd_wr && fast && pwdata[12:0] == 13'h12A4
      |=> instr_busy [*8] ##1 instr_busy ##1 (!instr_busy && instr_done);
  endproperty
  a_mac_nine: assert property (p_mac_nine) else $error("MAC not nine cycles");
  property p_clr_two;
    cmd_wr && fast && pwdata[12:0] == 13'h12E4 |=> instr_busy [*2] ##1 !instr_busy;
  endproperty
  a_clr_two: assert property (p_clr_two) else $error("clear not two cycles");
  property p_done_end;
    $fell(instr_busy) |-> instr_done;
  endproperty
  a_done_end: assert property (p_done_end) else $error("done missing");
  property p_done_once;
    instr_done |=> !instr_done;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done too long");
endmodule

bind cmu_core_timing cmu_core_timing_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compat_fuse(compat_fuse), .fetch_req(fetch_req), .instr_busy(instr_busy),
  .instr_done(instr_done));

// ===== test/cmu_code_mem_model.sv
// Code memory stand-in that hands out one byte per fetch strobe
module cmu_code_mem_model (
  // Clock, reset and fetch strobe
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fetch_req,
  // Bytes handed out, including the one in this cycle
  output int        total
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  // Current strobe is added so a byte fetched on the done edge is not missed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 0;
    else if (fetch_req === 1'b1) cnt <= cnt + 1;
  end
  assign total = cnt + (fetch_req === 1'b1 ? 1 : 0);
endmodule

// ===== test/cmu_core_timing_tb.sv
// Self-checking bench for the CPU timing and MAC unit
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module cmu_core_timing_tb
  import cmu_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, compat_fuse = 0, cm = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, fetch_req, instr_busy, instr_done;
  logic [32:0] rq[$], er;
  int iq[$], ei, n_errors = 0, checks = 0, bc = 0, last_f = 0, total;
  logic signed [39:0] m;
  logic [15:0] a, b, pr;
  logic [7:0] x, y;
  logic [14:0] ft[6] = '{15'h0100, 15'h0200, 15'h0300, 15'h0600, 15'h0900, 15'h0E00};
  logic [14:0] ct[5] = '{15'h0100, 15'h2A00, 15'h4100, 15'h6900, 15'h32A4};
  always #12.5 pclk = ~pclk;
  cmu_core_timing DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compat_fuse(compat_fuse), .fetch_req(fetch_req),
    .instr_busy(instr_busy), .instr_done(instr_done));
  cmu_code_mem_model u_mem (.pclk(pclk), .presetn(presetn), .fetch_req(fetch_req),
    .total(total));
  // ------------------------------------------------------------
  // Bus and instruction tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Request is held until pready is seen; an idle cycle keeps strobes single
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    apb(1'b1, ix, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] ix, input logic [32:0] ex);
    rq.push_back(ex);
    apb(1'b0, ix, 32'h0);
  endtask
  // Expected length: bytes plus branch, 3x off-chip; compat uses 12 per machine cycle
  task automatic run(input logic [14:0] c);
    int n, k;
    n = c[12] ? (c[7:0] == OPC_MULTIPLY_ACCUMULATE_INSTR ? 9 : 2) : (c[9:8] == 0 ? 1 : c[9:8]) + c[10];
    if (cm) n = c[14:13] == 0 ? 12 : (c[14] ? 48 : 24);
    else if (c[11]) n = 3 * n;
    iq.push_back(n * 256 + (c[12] ? 2 : (c[9:8] == 0 ? 1 : c[9:8])));
    apb(1'b1, IDX_CMD, {17'h0, c});
    for (k = 0; k < 80 && instr_done !== 1'b1; k++) @(posedge pclk);
  endtask
  // Sweep all four window positions with both sign bits set
  task automatic wins();
    for (int w = 0; w < 4; w++) begin
      wr(IDX_DSP_CFG, {w[1:0], 6'h30});
      rd(IDX_DSP_CFG, {25'h0, w[1:0], 6'h30});
      rd(IDX_WIN_LO, {25'h0, m[8*w +: 8]});
      rd(IDX_WIN_HI, {25'h0, m[8*w+8 +: 8]});
    end
  endtask
  // ------------------------------------------------------------
  // Result monitor: oldest note against what appears
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && !pwrite) begin
      er = rq.pop_front();
      `CHK("read", er, {pslverr, prdata})
    end
    if (instr_done === 1'b1) begin
      ei = iq.pop_front();
      `CHK("cycles", ei >> 8, bc)
      `CHK("fetches", ei & 255, total - last_f)
      last_f = total;
      bc = 0;
    end
    if (instr_busy === 1'b1) bc++;
  end
  // Watchdog: the whole sequence needs well under a thousand clocks
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(94));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(IDX_DSP_CFG, 33'h0);
    rd(8'hFF, {1'b1, 32'h0});
    foreach (ft[i]) run(ft[i] | 15'($urandom & 32'h7F));
    a = 16'($urandom);
    b = 16'($urandom);
    wr(IDX_OPA_HI, a[15:8]);
    wr(IDX_ACC, a[7:0]);
    wr(IDX_OPB_HI, b[15:8]);
    wr(IDX_B, b[7:0]);
    wr(IDX_DSP_CFG, 8'h30);
    run(15'h12E4);
    run(15'h12A4);
    m = $signed(a) * $signed(b);
    wins();
    rd(IDX_FLAGS, {25'h0, m[39], 7'h0});
    wr(IDX_FLAGS, 8'h04);
    run(15'h12A4);
    m = m + $signed(a) * $signed(b);
    wins();
    rd(IDX_FLAGS, {25'h0, m[39], 4'h0, 1'b1, 2'h0});
    rd(IDX_OPA_HI, {25'h0, a[15:8]});
    rd(IDX_ACC, {25'h0, a[7:0]});
    rd(IDX_OPB_HI, {25'h0, b[15:8]});
    rd(IDX_B, {25'h0, b[7:0]});
    run(15'h1223);
    m = m <<< 1;
    wins();
    run(15'h1203);
    m = m >>> 1;
    wins();
    wr(IDX_WIN_LO, a[7:0]);
    m[31:24] = a[7:0];
    wins();
    for (int s = 0; s < 4; s++) begin
      x = 8'($urandom);
      y = 8'($urandom);
      wr(IDX_ACC, x);
      wr(IDX_B, y);
      wr(IDX_DSP_CFG, {2'b00, s[1:0], 4'h0});
      run(15'h01A4);
      pr = (s[0] ? {{8{x[7]}}, x} : {8'h0, x}) * (s[1] ? {{8{y[7]}}, y} : {8'h0, y});
      rd(IDX_B, {25'h0, pr[15:8]});
      rd(IDX_ACC, {25'h0, pr[7:0]});
    end
    compat_fuse <= 1'b1;
    cm = 1'b1;
    repeat (4) @(posedge pclk);
    foreach (ct[i]) run(ct[i]);
    give_verdict();
  end
endmodule
